// [pkg/dlpoc_pkg.sv]
package dlpoc_pkg;
  // register offsets
  localparam logic [4:0] DLPOC_DELAY_LOOP_CONTROL_ADDR = 5'h08;
  localparam logic [4:0] DLPOC_SYNTH_DIVIDER_CONFIG_ADDR = 5'h09;
  localparam logic [4:0] DLPOC_DELAY_LOOP_TUNING_ADDR = 5'h0A;
  localparam logic [4:0] DLPOC_SYNTH_OSC_TUNING_ADDR = 5'h0B;
  localparam logic [4:0] DLPOC_OFFSET_STROBE_CHAN_A_HIGH_ADDR = 5'h0C;
  localparam logic [4:0] DLPOC_CHAN_A_OFFSET_LOW_ADDR = 5'h0D;
  localparam logic [4:0] DLPOC_OUT_SELECT_CHAN_B_HIGH_ADDR = 5'h0E;
  localparam logic [4:0] DLPOC_CHAN_B_OFFSET_LOW_ADDR = 5'h0F;
  localparam logic [7:0] DLPOC_REG_RESET = 8'h00;
  // field positions
  localparam int DLPOC_RELOCK_BIT = 3;
  localparam int DLPOC_MULT_LSB = 3;
  localparam int DLPOC_MULT_W = 5;
  localparam int DLPOC_REFDIV_W = 3;
  localparam int DLPOC_TRIM_LSB = 4;
  localparam int DLPOC_TRIM_W = 4;
  localparam int DLPOC_INVCLK_BIT = 3;
  localparam int DLPOC_BIAS_W = 3;
  localparam int DLPOC_CLAMP_BIT = 7;
  localparam int DLPOC_HALF_BIT = 6;
  localparam int DLPOC_GAIN_LSB = 4;
  localparam int DLPOC_GAIN_W = 2;
  localparam int DLPOC_RANGE_W = 4;
  localparam int DLPOC_STROBE_BIT = 5;
  localparam int DLPOC_HIGH_W = 5;
  localparam int DLPOC_SEL_LSB = 5;
  localparam int DLPOC_OFFSET_W = 13;
  // serial output source codes
  localparam logic [2:0] DLPOC_SEL_SYNTH_LOCK = 3'h1;
  localparam logic [2:0] DLPOC_SEL_DLOOP_LOCK = 3'h2;
  localparam logic [2:0] DLPOC_SEL_PATTERN_ERR = 3'h3;
  localparam logic [2:0] DLPOC_SEL_BUFFER_ERR = 3'h4;
  localparam logic [2:0] DLPOC_SEL_SELF_CHECK = 3'h5;
endpackage

// [design/dlpoc_thermo_decode.sv]
// thermometer code to power-of-two ratio; invalid codes flagged
module dlpoc_thermo_decode #(
  parameter int W = 5
) (
  input wire logic [W-1:0] code_i,
  output logic [W:0] ratio_o,
  output logic valid_o
);
  always_comb begin
    ratio_o = '0;
    valid_o = 1'b0;
    for (int k = 0; k <= W; k++) begin
      if (code_i == W'((1 << k) - 1)) begin
        ratio_o = (W+1)'(1 << k);
        valid_o = 1'b1;
      end
    end
  end
endmodule

// [design/dlpoc_regs.sv]
// What this block does
// - relock bit set: filter zero, delay centred
// - relock bit cleared: start acquiring lock
// - setting relock clears delay-loop locked flag
// - feedback multiplier thermometer coded, others invalid
// - reference divider thermometer coded, others invalid
// - skew trim signed 5-degree steps around 90
// - invert bit inverts internal delay-loop clock
// - clamp bit holds synth filter at zero
// - half-rate bit halves oscillator output clock
// - oscillator range with gain sets VCO bias
// - strobe rising edge loads both channel offsets
// - offset strobe never clears itself
// - offset split high five, low eight bits
// - source select routes status onto serial pin
// - three-pin mode multiplexes status onto pin
// - four-pin mode status select overrides read data
module dlpoc_regs
  import dlpoc_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic WR_EN_I,
  input wire logic RD_EN_I,
  input wire logic [4:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  output logic RHIT_O,
  input wire logic FOUR_PIN_MODE_I,
  input wire logic SERIAL_READ_BIT_I,
  input wire logic SYNTH_LOCK_I,
  input wire logic DLOOP_LOCK_RAW_I,
  input wire logic PATTERN_ERR_I,
  input wire logic BUFFER_ERR_I,
  input wire logic SELF_CHECK_ERR_I,
  output logic SERIAL_DATA_OUT_PIN_O,
  output logic SERIAL_OVERRIDE_O,
  output logic DLOOP_LOCKED_O,
  output logic DLOOP_FILTER_CLEAR_O,
  output logic DLOOP_DELAY_CENTRE_O,
  output logic DLOOP_ACQUIRE_O,
  output logic DLOOP_CLK_INVERT_O,
  output logic [3:0] DLOOP_TRIM_O,
  output logic [2:0] DLOOP_BIAS_O,
  output logic [5:0] SYNTH_MULT_O,
  output logic SYNTH_MULT_VALID_O,
  output logic [3:0] SYNTH_REFDIV_O,
  output logic SYNTH_REFDIV_VALID_O,
  output logic SYNTH_FILTER_CLAMP_O,
  output logic OSC_HALF_RATE_O,
  output logic [1:0] OSC_GAIN_O,
  output logic [3:0] OSC_RANGE_O,
  output logic [12:0] CHAN_A_OFFSET_O,
  output logic [12:0] CHAN_B_OFFSET_O
);
  logic [7:0] dctl_reg, sdiv_reg, dtun_reg, sosc_reg;
  logic [7:0] ahi_reg, alo_reg, bhi_reg, blo_reg;
  logic strobe_d_reg;
  logic dlock_s1_reg, dlock_s2_reg, dlocked_reg;
  logic [4:0] st_s1_reg, st_s2_reg;
  logic [5:0] mult_next;
  logic [3:0] refdiv_next;
  logic mult_ok, refdiv_ok, sel_bit_next, status_sel;
  logic [2:0] src_sel;

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      dctl_reg <= DLPOC_REG_RESET;
      sdiv_reg <= DLPOC_REG_RESET;
      dtun_reg <= DLPOC_REG_RESET;
      sosc_reg <= DLPOC_REG_RESET;
      ahi_reg <= DLPOC_REG_RESET;
      alo_reg <= DLPOC_REG_RESET;
      bhi_reg <= DLPOC_REG_RESET;
      blo_reg <= DLPOC_REG_RESET;
    end else if (WR_EN_I) begin
      // strobe is only host-written, never cleared here
      unique case (ADDR_I)
        DLPOC_DELAY_LOOP_CONTROL_ADDR: dctl_reg <= WDATA_I;
        DLPOC_SYNTH_DIVIDER_CONFIG_ADDR: sdiv_reg <= WDATA_I;
        DLPOC_DELAY_LOOP_TUNING_ADDR: dtun_reg <= WDATA_I;
        DLPOC_SYNTH_OSC_TUNING_ADDR: sosc_reg <= WDATA_I;
        DLPOC_OFFSET_STROBE_CHAN_A_HIGH_ADDR: ahi_reg <= WDATA_I;
        DLPOC_CHAN_A_OFFSET_LOW_ADDR: alo_reg <= WDATA_I;
        DLPOC_OUT_SELECT_CHAN_B_HIGH_ADDR: bhi_reg <= WDATA_I;
        DLPOC_CHAN_B_OFFSET_LOW_ADDR: blo_reg <= WDATA_I;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads, one cycle latency
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
      RHIT_O <= 1'b0;
    end else begin
      RHIT_O <= 1'b0;
      RDATA_O <= 8'h00;
      if (RD_EN_I) begin
        RHIT_O <= (ADDR_I[4:3] == 2'h1);
        unique case (ADDR_I)
          DLPOC_DELAY_LOOP_CONTROL_ADDR: RDATA_O <= dctl_reg;
          DLPOC_SYNTH_DIVIDER_CONFIG_ADDR: RDATA_O <= sdiv_reg;
          DLPOC_DELAY_LOOP_TUNING_ADDR: RDATA_O <= dtun_reg;
          DLPOC_SYNTH_OSC_TUNING_ADDR: RDATA_O <= sosc_reg;
          DLPOC_OFFSET_STROBE_CHAN_A_HIGH_ADDR: RDATA_O <= ahi_reg;
          DLPOC_CHAN_A_OFFSET_LOW_ADDR: RDATA_O <= alo_reg;
          DLPOC_OUT_SELECT_CHAN_B_HIGH_ADDR: RDATA_O <= bhi_reg;
          DLPOC_CHAN_B_OFFSET_LOW_ADDR: RDATA_O <= blo_reg;
          default: RDATA_O <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // delay loop control; restart pairing and reserved zeros are host duties
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      DLOOP_FILTER_CLEAR_O <= 1'b0;
      DLOOP_DELAY_CENTRE_O <= 1'b0;
      DLOOP_ACQUIRE_O <= 1'b0;
      DLOOP_CLK_INVERT_O <= 1'b0;
      DLOOP_TRIM_O <= 4'h0;
      DLOOP_BIAS_O <= 3'h0;
    end else begin
      DLOOP_FILTER_CLEAR_O <= dctl_reg[DLPOC_RELOCK_BIT];
      DLOOP_DELAY_CENTRE_O <= dctl_reg[DLPOC_RELOCK_BIT];
      DLOOP_ACQUIRE_O <= !dctl_reg[DLPOC_RELOCK_BIT];
      DLOOP_CLK_INVERT_O <= dtun_reg[DLPOC_INVCLK_BIT];
      // signed trim: 1000 is -8 steps (50 deg), 0111 is +7 (125 deg)
      DLOOP_TRIM_O <= dtun_reg[DLPOC_TRIM_LSB +: DLPOC_TRIM_W];
      DLOOP_BIAS_O <= dtun_reg[DLPOC_BIAS_W-1:0];
    end
  end

  // lock input is from the loop's own clock domain, so synchronise first
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      dlock_s1_reg <= 1'b0;
      dlock_s2_reg <= 1'b0;
      dlocked_reg <= 1'b0;
      DLOOP_LOCKED_O <= 1'b0;
    end else begin
      dlock_s1_reg <= DLOOP_LOCK_RAW_I;
      dlock_s2_reg <= dlock_s1_reg;
      dlocked_reg <= dlock_s2_reg && !dctl_reg[DLPOC_RELOCK_BIT];
      DLOOP_LOCKED_O <= dlock_s2_reg && !dctl_reg[DLPOC_RELOCK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synthesizer dividers and oscillator
  dlpoc_thermo_decode #(.W(DLPOC_MULT_W)) u_mult (
    .code_i(sdiv_reg[DLPOC_MULT_LSB +: DLPOC_MULT_W]),
    .ratio_o(mult_next),
    .valid_o(mult_ok)
  );

  dlpoc_thermo_decode #(.W(DLPOC_REFDIV_W)) u_refdiv (
    .code_i(sdiv_reg[DLPOC_REFDIV_W-1:0]),
    .ratio_o(refdiv_next),
    .valid_o(refdiv_ok)
  );

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      SYNTH_MULT_O <= 6'h01;
      SYNTH_MULT_VALID_O <= 1'b1;
      SYNTH_REFDIV_O <= 4'h1;
      SYNTH_REFDIV_VALID_O <= 1'b1;
      SYNTH_FILTER_CLAMP_O <= 1'b0;
      OSC_HALF_RATE_O <= 1'b0;
      OSC_GAIN_O <= 2'h0;
      OSC_RANGE_O <= 4'h0;
    end else begin
      SYNTH_MULT_O <= mult_next;
      SYNTH_MULT_VALID_O <= mult_ok;
      SYNTH_REFDIV_O <= refdiv_next;
      SYNTH_REFDIV_VALID_O <= refdiv_ok;
      SYNTH_FILTER_CLAMP_O <= sosc_reg[DLPOC_CLAMP_BIT];
      OSC_HALF_RATE_O <= sosc_reg[DLPOC_HALF_BIT];
      OSC_GAIN_O <= sosc_reg[DLPOC_GAIN_LSB +: DLPOC_GAIN_W];
      OSC_RANGE_O <= sosc_reg[DLPOC_RANGE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // double-buffered offsets; level strobe would reload every cycle, so edge
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      strobe_d_reg <= 1'b0;
      CHAN_A_OFFSET_O <= 13'h0000;
      CHAN_B_OFFSET_O <= 13'h0000;
    end else begin
      strobe_d_reg <= ahi_reg[DLPOC_STROBE_BIT];
      if (ahi_reg[DLPOC_STROBE_BIT] && !strobe_d_reg) begin
        CHAN_A_OFFSET_O <= {ahi_reg[DLPOC_HIGH_W-1:0], alo_reg};
        CHAN_B_OFFSET_O <= {bhi_reg[DLPOC_HIGH_W-1:0], blo_reg};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output source mux
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st_s1_reg <= 5'h00;
      st_s2_reg <= 5'h00;
    end else begin
      st_s1_reg <= {SELF_CHECK_ERR_I, BUFFER_ERR_I, PATTERN_ERR_I, 1'b0, SYNTH_LOCK_I};
      st_s2_reg <= st_s1_reg;
    end
  end

  assign src_sel = bhi_reg[DLPOC_SEL_LSB +: 3];

  always_comb begin
    status_sel = 1'b1;
    sel_bit_next = 1'b0;
    unique case (src_sel)
      DLPOC_SEL_SYNTH_LOCK: sel_bit_next = st_s2_reg[0];
      DLPOC_SEL_DLOOP_LOCK: sel_bit_next = dlocked_reg;
      DLPOC_SEL_PATTERN_ERR: sel_bit_next = st_s2_reg[2];
      DLPOC_SEL_BUFFER_ERR: sel_bit_next = st_s2_reg[3];
      DLPOC_SEL_SELF_CHECK: sel_bit_next = st_s2_reg[4];
      default: status_sel = 1'b0;
    endcase
  end

  // read bit comes from serial logic on this clock, no synchroniser
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      SERIAL_DATA_OUT_PIN_O <= 1'b0;
      SERIAL_OVERRIDE_O <= 1'b0;
    end else begin
      // either pin mode: status wins whenever selected
      SERIAL_DATA_OUT_PIN_O <= status_sel ? sel_bit_next : SERIAL_READ_BIT_I;
      SERIAL_OVERRIDE_O <= status_sel && FOUR_PIN_MODE_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_relock_clears;
    @(posedge MCLK_I) disable iff (RST_I)
    dctl_reg[DLPOC_RELOCK_BIT] |=> !DLOOP_LOCKED_O;
  endproperty
  a_relock_clears: assert property (p_relock_clears) else $error("lock not cleared");

  property p_relock_hold;
    @(posedge MCLK_I) disable iff (RST_I)
    dctl_reg[DLPOC_RELOCK_BIT] |=>
      DLOOP_FILTER_CLEAR_O && DLOOP_DELAY_CENTRE_O && !DLOOP_ACQUIRE_O;
  endproperty
  a_relock_hold: assert property (p_relock_hold) else $error("relock hold wrong");

  property p_acquire;
    @(posedge MCLK_I) disable iff (RST_I)
    $fell(dctl_reg[DLPOC_RELOCK_BIT]) |=> DLOOP_ACQUIRE_O && !DLOOP_FILTER_CLEAR_O;
  endproperty
  a_acquire: assert property (p_acquire) else $error("no acquire");

  property p_mult_code;
    @(posedge MCLK_I) disable iff (RST_I)
    (sdiv_reg[7:3] == 5'h07) |=> (SYNTH_MULT_O == 6'h08) && SYNTH_MULT_VALID_O;
  endproperty
  a_mult_code: assert property (p_mult_code) else $error("multiplier decode wrong");

  property p_refdiv_bad;
    @(posedge MCLK_I) disable iff (RST_I)
    (sdiv_reg[2:0] == 3'h5) |=> !SYNTH_REFDIV_VALID_O;
  endproperty
  a_refdiv_bad: assert property (p_refdiv_bad) else $error("invalid divider accepted");

  property p_offset_load;
    @(posedge MCLK_I) disable iff (RST_I)
    $rose(ahi_reg[DLPOC_STROBE_BIT]) |=> CHAN_A_OFFSET_O == $past({ahi_reg[4:0], alo_reg});
  endproperty
  a_offset_load: assert property (p_offset_load) else $error("offset not loaded");

  property p_offset_hold;
    @(posedge MCLK_I) disable iff (RST_I)
    !(ahi_reg[DLPOC_STROBE_BIT] && !strobe_d_reg) |=> $stable(CHAN_B_OFFSET_O);
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("offset changed w/o edge");

  property p_strobe_sticky;
    @(posedge MCLK_I) disable iff (RST_I)
    ahi_reg[DLPOC_STROBE_BIT] && !WR_EN_I |=> ahi_reg[DLPOC_STROBE_BIT];
  endproperty
  a_strobe_sticky: assert property (p_strobe_sticky) else $error("strobe self-cleared");

  property p_sel_dlock;
    @(posedge MCLK_I) disable iff (RST_I)
    (src_sel == DLPOC_SEL_DLOOP_LOCK) |=> SERIAL_DATA_OUT_PIN_O == $past(dlocked_reg);
  endproperty
  a_sel_dlock: assert property (p_sel_dlock) else $error("serial source wrong");

  property p_override;
    @(posedge MCLK_I) disable iff (RST_I)
    FOUR_PIN_MODE_I && (src_sel == DLPOC_SEL_BUFFER_ERR) |=> SERIAL_OVERRIDE_O;
  endproperty
  a_override: assert property (p_override) else $error("no override");
endmodule

// [verification/dlpoc_host_model.sv]
// host side of the configuration bus: one strobe per call, never back to back
module dlpoc_host_model (
  input wire logic clk_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [4:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // a restart always takes two calls, set then clear
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 5'h08) v = v & 8'h08;
    if (a == 5'h0A && v[2:0] == 3'h4) v[2:0] = 3'h3;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b1;
    addr_o = a;
    wdata_o = v;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    // released lines show a changed value, not the last one
    addr_o = ~a;
    wdata_o = ~v;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_i);
    #1;
    rd_en_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    rd_en_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule

// [verification/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic four_pin = 1'b0;
  logic rd_bit = 1'b0;
  logic [4:0] st = 5'h00;
  logic wr_en, rd_en, rhit, serial_data_out_pin, ovr, locked, fclr, ctr, acq, inv, mv, nv, clamp, half;
  logic [4:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] trim, refdiv, range_v;
  logic [2:0] bias;
  logic [5:0] mult;
  logic [1:0] gain;
  logic [12:0] oa, ob;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h2787;
  logic [7:0] qd[$];
  logic qh[$];
  logic [7:0] r [8:15];
  logic rd_pend = 1'b0;
  always #2 mclk = ~mclk;
  dlpoc_host_model dlpoc_host_model_i (.clk_i(mclk), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .addr_o(addr), .wdata_o(wdata));
  dlpoc_regs dlpoc_regs_i (.MCLK_I(mclk), .RST_I(rst), .WR_EN_I(wr_en), .RD_EN_I(rd_en),
    .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .RHIT_O(rhit),
    .FOUR_PIN_MODE_I(four_pin), .SERIAL_READ_BIT_I(rd_bit), .SYNTH_LOCK_I(st[0]),
    .DLOOP_LOCK_RAW_I(st[1]), .PATTERN_ERR_I(st[2]), .BUFFER_ERR_I(st[3]),
    .SELF_CHECK_ERR_I(st[4]), .SERIAL_DATA_OUT_PIN_O(serial_data_out_pin), .SERIAL_OVERRIDE_O(ovr),
    .DLOOP_LOCKED_O(locked), .DLOOP_FILTER_CLEAR_O(fclr), .DLOOP_DELAY_CENTRE_O(ctr),
    .DLOOP_ACQUIRE_O(acq), .DLOOP_CLK_INVERT_O(inv), .DLOOP_TRIM_O(trim),
    .DLOOP_BIAS_O(bias), .SYNTH_MULT_O(mult), .SYNTH_MULT_VALID_O(mv),
    .SYNTH_REFDIV_O(refdiv), .SYNTH_REFDIV_VALID_O(nv), .SYNTH_FILTER_CLAMP_O(clamp),
    .OSC_HALF_RATE_O(half), .OSC_GAIN_O(gain), .OSC_RANGE_O(range_v),
    .CHAN_A_OFFSET_O(oa), .CHAN_B_OFFSET_O(ob));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] d, input logic h);
    qd.push_back(d);
    qh.push_back(h);
    dlpoc_host_model_i.rd(a);
  endtask
  // read data stands one cycle only, so it is taken at the edge ending that cycle
  always @(posedge mclk) begin
    if (rd_pend && qd.size() > 0) begin
      chk(rdata, qd.pop_front());
      chk(rhit, qh.pop_front());
    end
    rd_pend <= rd_en;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("unexpected at %0t: run timed out", $time);
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [4:0] m;
    logic [2:0] n;
    logic [2:0] sel;
    logic e;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    settle(1);
    chk({mult, mv, refdiv, nv, acq}, {6'h01, 1'b1, 4'h1, 1'b1, 1'b1});
    for (int a = 8; a < 16; a++) rchk(a[4:0], 8'h00, 1'b1);
    rchk(5'h10, 8'h00, 1'b0);
    for (int a = 8; a < 16; a++) begin
      d = 8'(rnd());
      if (a == 8) d = d & 8'h08;
      if (a == 10 && d[2:0] == 3'h4) d[2:0] = 3'h3;
      r[a] = d;
      dlpoc_host_model_i.wr(a[4:0], d);
    end
    for (int a = 8; a < 16; a++) rchk(a[4:0], r[a], 1'b1);
    chk({trim, inv, bias}, r[10]);
    chk({clamp, half, gain, range_v}, r[11]);
    // tuning just changed and raw lock is high: restart the delay loop
    st = 5'h02;
    dlpoc_host_model_i.wr(5'h08, 8'h00);
    settle(4);
    chk(locked, 1'b1);
    dlpoc_host_model_i.wr(5'h08, 8'h08);
    settle(4);
    chk({fclr, ctr, acq, locked}, 4'hC);
    dlpoc_host_model_i.wr(5'h08, 8'h00);
    settle(4);
    chk({fclr, ctr, acq, locked}, 4'h3);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'hB7 : 8'h40;
      dlpoc_host_model_i.wr(5'h0B, d);
      settle(2);
      chk({clamp, half, gain, range_v}, d);
    end
    // reference clock is slow here, so any divider keeps the detector rate in limit
    for (int i = 0; i < 7; i++) begin
      m = (i < 6) ? 5'((1 << i) - 1) : 5'h02;
      n = (i < 4) ? 3'((1 << i) - 1) : ((i == 4) ? 3'h2 : 3'h5);
      dlpoc_host_model_i.wr(5'h09, {m, n});
      settle(2);
      chk({mult, mv}, (i < 6) ? 7'(((1 << i) << 1) | 1) : 7'h00);
      chk({refdiv, nv}, (i < 4) ? 5'(((1 << i) << 1) | 1) : 5'h00);
    end
    // host clears the strobe before the first staging; the second is staged with the strobe still set
    dlpoc_host_model_i.wr(5'h0C, 8'h15);
    dlpoc_host_model_i.wr(5'h0D, 8'hA7);
    dlpoc_host_model_i.wr(5'h0E, 8'h0B);
    dlpoc_host_model_i.wr(5'h0F, 8'h3C);
    dlpoc_host_model_i.wr(5'h0C, 8'h35);
    settle(2);
    chk(oa, 13'h15A7);
    chk(ob, 13'h0B3C);
    dlpoc_host_model_i.wr(5'h0D, 8'h11);
    dlpoc_host_model_i.wr(5'h0C, 8'h35);
    settle(2);
    chk(oa, 13'h15A7);
    rchk(5'h0C, 8'h35, 1'b1);
    dlpoc_host_model_i.wr(5'h0C, 8'h15);
    dlpoc_host_model_i.wr(5'h0C, 8'h35);
    settle(2);
    chk(oa, 13'h1511);
    for (int k = 0; k < 16; k++) begin
      sel = k[2:0];
      four_pin = k[3];
      st = 5'(rnd());
      rd_bit = ~rd_bit;
      dlpoc_host_model_i.wr(5'h0E, {sel, 5'h00});
      settle(4);
      e = (sel >= 3'h1 && sel <= 3'h5);
      chk(serial_data_out_pin, e ? st[sel - 3'h1] : rd_bit);
      chk(ovr, e & four_pin);
    end
    settle(2);
    chk(13'(qd.size()), 13'h0000);
    end_sim();
  end
endmodule
